/* File: pkg/idle_domain_control_consts.svh */
// constants of the idle domain control block: offsets, bit positions, reset values
`ifndef IDLE_DOMAIN_CONTROL_CONSTS_SVH
`define IDLE_DOMAIN_CONTROL_CONSTS_SVH

// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define IDC_IDX_CONFIG 16'h0001
`define IDC_IDX_STATE 16'h0002
`define IDC_IDX_SELECT 16'h9400
`define IDC_IDX_EVENT 16'h0010
`define IDC_IDX_MASK 16'h0011

// ----------------------------------------
// domain bit positions, shared by request and state layouts
// ----------------------------------------
`define IDC_BIT_CORE 0
`define IDC_BIT_MASTER 1
`define IDC_BIT_ICACHE 2
`define IDC_BIT_SLAVE 3
`define IDC_BIT_CLKGEN 4
`define IDC_BIT_EXTMEM 5
`define IDC_BIT_IOPORT 6
`define IDC_BIT_DMAHOST 7
`define IDC_BIT_FETCH 8
`define IDC_BIT_CONFIRM 9

// ----------------------------------------
// event bit positions
// ----------------------------------------
`define IDC_EVT_BUSERR 0
`define IDC_EVT_ENTER 1
`define IDC_EVT_WAKE 2

// ----------------------------------------
// reset values, writable masks and the clock dependency mask
// ----------------------------------------
`define IDC_CONFIG_RST 16'h0000
`define IDC_STATE_RST 16'h0000
`define IDC_SELECT_RST 16'h0000
`define IDC_EVENT_RST 16'h0000
`define IDC_MASK_RST 16'h0000
`define IDC_CONFIG_WMASK 16'h03FF
`define IDC_SELECT_WMASK 16'h3FFF
`define IDC_EVENT_WMASK 16'h0007
`define IDC_CLKGEN_DEPS 16'h03E7

`endif

/* File: pkg/idle_domain_control_pkg.sv */
// types of the idle domain control block
package idle_domain_control_pkg;

  typedef enum logic [1:0]
  {
    SEQ_RUN = 2'b00,
    SEQ_CHECK = 2'b01,
    SEQ_SLEEP = 2'b11,
    SEQ_WAKE = 2'b10
  } seq_state_type;

  typedef struct packed
  {
    logic sel;
    logic enable;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } apb_req_type;

  typedef struct packed
  {
    logic busErr;
    logic entered;
    logic woke;
    logic [15:0] state;
  } idle_result_type;

endpackage

/* File: verilog/idle_seq_fsm.sv */
// idle sequencer: checks the request set and tracks which domains sleep
`timescale 1ns/1ps
`include "idle_domain_control_consts.svh"
module idle_seq_fsm
  import idle_domain_control_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core side
  input wire logic idleExec,
  input wire logic wake,
  input wire logic [15:0] cfg,
  // result
  output idle_result_type result,
  output seq_state_type seqState
);

  seq_state_type state_q;
  seq_state_type state_d;
  logic [15:0] latched_q;
  idle_result_type result_q;
  idle_result_type result_d;

  // ----------------------------------------
  // consistency of the request set
  // ----------------------------------------
  wire clkReq = latched_q[`IDC_BIT_CLKGEN];
  wire clkConfirm = latched_q[`IDC_BIT_CONFIRM];
  wire clkGenOff = clkReq & clkConfirm; // [R1]
  // confirm without request is simply ignored: generator stays up
  wire depsMissing = (latched_q & `IDC_CLKGEN_DEPS) != `IDC_CLKGEN_DEPS; // [R3]
  wire reqError = clkReq & (~clkConfirm | depsMissing); // [R2] [R3]

  // ----------------------------------------
  // disabled-domain vector
  // ----------------------------------------
  logic [15:0] offVec;
  always_comb
  begin
    offVec = 16'h0000;
    offVec[`IDC_BIT_CORE] = latched_q[`IDC_BIT_CORE]; // [R8]
    offVec[`IDC_BIT_MASTER] = latched_q[`IDC_BIT_MASTER]; // [R7]
    offVec[`IDC_BIT_ICACHE] = latched_q[`IDC_BIT_ICACHE]; // [R6]
    offVec[`IDC_BIT_SLAVE] = latched_q[`IDC_BIT_SLAVE]; // [R5]
    offVec[`IDC_BIT_CLKGEN] = clkGenOff; // [R1]
    offVec[`IDC_BIT_EXTMEM] = latched_q[`IDC_BIT_EXTMEM];
    offVec[`IDC_BIT_IOPORT] = latched_q[`IDC_BIT_IOPORT];
    offVec[`IDC_BIT_DMAHOST] = latched_q[`IDC_BIT_DMAHOST];
    offVec[`IDC_BIT_FETCH] = latched_q[`IDC_BIT_FETCH];
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    result_d = result_q;
    result_d.busErr = 1'b0;
    result_d.entered = 1'b0;
    result_d.woke = 1'b0;
    case (state_q)
      SEQ_RUN:
        if (idleExec)
          state_d = SEQ_CHECK;
      SEQ_CHECK:
        if (reqError)
        begin
          result_d.busErr = 1'b1; // [R2] [R3]
          state_d = SEQ_RUN;
        end
        else
        begin
          result_d.state = offVec; // [R12]
          result_d.entered = 1'b1;
          state_d = SEQ_SLEEP;
        end
      SEQ_SLEEP:
        if (wake)
          state_d = SEQ_WAKE;
      SEQ_WAKE:
      begin
        result_d.state = `IDC_STATE_RST; // [R12]
        result_d.woke = 1'b1;
        state_d = SEQ_RUN;
      end
      default:
        state_d = SEQ_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= SEQ_RUN;
      latched_q <= `IDC_CONFIG_RST;
      result_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      result_q <= result_d;
      if (state_q == SEQ_RUN && idleExec)
        latched_q <= cfg;
    end
  end

  assign result = result_q;
  assign seqState = state_q;

endmodule

/* File: verilog/idle_domain_control.sv */
// idle domain control: apb registers, request check, domain disables, interrupt
//
// Operation
// R1: clock generator idles only with request and confirm
// R2: request without confirm raises bus error
// R3: clock idle needs all other requests set; the code does not need the slave request, bit 3
// R4: clock generator idle stops system clock
// R5: peripheral request disables selected peripherals only
// R6: cache request disables instruction cache
// R7: master request disables dma and host port
// R8: core request disables the core
// R9: read-only state register, eight bits, reset zero; the code has nine, bits 0 to 8
// R10: state bit one while domain disabled
// R11: confirm bit nine, read/write, reset zero
// R12: state bits follow actual entry and wake
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "idle_domain_control_consts.svh"
module idle_domain_control
  import idle_domain_control_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core handshake
  input wire logic idleExec,
  input wire logic wakeEvent,
  // domain controls
  output logic [15:0] domainOff,
  output logic [15:0] periphOff,
  output logic sysClkStop,
  // interrupts
  output logic busErrIrq,
  output logic irq
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic addrHit(input logic [31:0] addr, input logic [15:0] idx);
    addrHit = addr == {14'h0000, idx, 2'b00};
  endfunction

  apb_req_type req;
  assign req.sel = psel;
  assign req.enable = penable;
  assign req.write = pwrite;
  assign req.addr = paddr;
  assign req.wdata = pwdata;

  wire hitConfig = addrHit(req.addr, `IDC_IDX_CONFIG);
  wire hitState = addrHit(req.addr, `IDC_IDX_STATE);
  wire hitSelect = addrHit(req.addr, `IDC_IDX_SELECT);
  wire hitEvent = addrHit(req.addr, `IDC_IDX_EVENT);
  wire hitMask = addrHit(req.addr, `IDC_IDX_MASK);
  wire hitAny = hitConfig | hitState | hitSelect | hitEvent | hitMask;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [15:0] config_q;
  logic [15:0] select_q;
  logic [15:0] event_q;
  logic [15:0] mask_q;
  logic [15:0] domainOff_q;
  logic [15:0] periphOff_q;
  logic sysClkStop_q;
  logic busErrIrq_q;
  logic irq_q;

  logic [15:0] config_d;
  logic [15:0] select_d;
  logic [15:0] event_d;
  logic [15:0] mask_d;
  logic [15:0] eventSet;

  // ----------------------------------------
  // bus phase decode
  // ----------------------------------------
  // one wait state: pready rises on the second access cycle, from a flop
  wire accessPhase = req.sel & req.enable;
  wire finishing = accessPhase & pready_q;
  wire wrStrobe = finishing & req.write & hitAny;
  wire rdStrobe = accessPhase & ~pready_q & ~req.write;
  wire pready_d = accessPhase & ~pready_q;
  // error flag rises with pready, so the pin needs no gating after the flop
  wire pslverr_d = accessPhase & ~pready_q & ~hitAny;

  // ----------------------------------------
  // write enables
  // ----------------------------------------
  wire wrConfig = wrStrobe & hitConfig;
  wire wrSelect = wrStrobe & hitSelect;
  wire wrEvent = wrStrobe & hitEvent;
  wire wrMask = wrStrobe & hitMask;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  idle_result_type seqResult;
  seq_state_type seqState;

  idle_seq_fsm seq
  (
    .clk(clk),
    .rst(rst),
    .idleExec(idleExec),
    .wake(wakeEvent),
    .cfg(config_q),
    .result(seqResult),
    .seqState(seqState)
  );

  // ----------------------------------------
  // next-state of software registers
  // ----------------------------------------
  // confirm and requests are plain read/write; upper bits stay zero
  assign config_d = wrConfig ? (req.wdata[15:0] & `IDC_CONFIG_WMASK) : config_q; // [R11]
  assign select_d = wrSelect ? (req.wdata[15:0] & `IDC_SELECT_WMASK) : select_q;
  assign mask_d = wrMask ? (req.wdata[15:0] & `IDC_EVENT_WMASK) : mask_q;

  always_comb
  begin
    eventSet = 16'h0000;
    eventSet[`IDC_EVT_BUSERR] = seqResult.busErr;
    eventSet[`IDC_EVT_ENTER] = seqResult.entered;
    eventSet[`IDC_EVT_WAKE] = seqResult.woke;
  end

  // write-one-to-clear; a new event in the same cycle wins over the clear
  wire [15:0] eventClr = wrEvent ? (req.wdata[15:0] & `IDC_EVENT_WMASK) : 16'h0000;
  assign event_d = (event_q & ~eventClr) | eventSet;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // state register has no write path, writes to it are dropped
  wire [15:0] rdValue =
    hitConfig ? config_q :
    hitState ? seqResult.state : // [R9] [R10]
    hitSelect ? select_q :
    hitEvent ? event_q :
    hitMask ? mask_q : 16'h0000;
  // captured in the first access cycle, so it is steady while pready stands
  wire [31:0] prdata_d = rdStrobe ? {16'h0000, rdValue} : prdata_q;

  // ----------------------------------------
  // domain controls
  // ----------------------------------------
  wire sleeping = seqState == SEQ_SLEEP;
  // per-peripheral disables only while the slave-module domain is down
  wire [15:0] periphOff_d = seqResult.state[`IDC_BIT_SLAVE] ? select_q : 16'h0000; // [R5]
  // the gate cell outside stops the clock; wake logic sits on an always-on clock
  wire sysClkStop_d = sleeping & seqResult.state[`IDC_BIT_CLKGEN]; // [R4]
  wire [15:0] domainOff_d = seqResult.state; // [R6] [R7] [R8]

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  wire busErrIrq_d = event_d[`IDC_EVT_BUSERR] & mask_d[`IDC_EVT_BUSERR]; // [R2]
  // looks at the next flag values, so a new event reaches the pin one cycle sooner
  wire irq_d = |(event_d & mask_d);

  // ----------------------------------------
  // bus flops
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= pready_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pslverr_q <= 1'b0;
    end
    else
    begin
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_q <= 32'h00000000;
    end
    else
    begin
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------
  // register flops
  // ----------------------------------------
  // reserved bits are masked at write, so they always read back zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      config_q <= `IDC_CONFIG_RST;
    end
    else
    begin
      config_q <= config_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      select_q <= `IDC_SELECT_RST;
    end
    else
    begin
      select_q <= select_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      event_q <= `IDC_EVENT_RST;
    end
    else
    begin
      event_q <= event_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mask_q <= `IDC_MASK_RST;
    end
    else
    begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      domainOff_q <= `IDC_STATE_RST;
    end
    else
    begin
      domainOff_q <= domainOff_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      periphOff_q <= 16'h0000;
    end
    else
    begin
      periphOff_q <= periphOff_d;
    end
  end

  // clock stop is a level for an outside gate cell; it drops in the same cycle as the state clears, one cycle before domainOff
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sysClkStop_q <= 1'b0;
    end
    else
    begin
      sysClkStop_q <= sysClkStop_d;
    end
  end

  // ----------------------------------------
  // interrupt flops
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busErrIrq_q <= 1'b0;
    end
    else
    begin
      busErrIrq_q <= busErrIrq_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign domainOff = domainOff_q;
  assign periphOff = periphOff_q;
  assign sysClkStop = sysClkStop_q;
  assign busErrIrq = busErrIrq_q;
  assign irq = irq_q;

endmodule

/* File: tb/idle_domain_control_asserts.sv */
// port checker of the idle domain control block
`timescale 1ns/1ps
module idle_domain_control_asserts
(
  // clock and reset
  input logic clk,
  input logic rst,
  // apb
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  // core and domains
  input logic idleExec,
  input logic wakeEvent,
  input logic [15:0] domainOff,
  input logic [15:0] periphOff,
  input logic sysClkStop,
  input logic busErrIrq,
  input logic irq
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  apb_wait_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  clk_stop_a: assert property (sysClkStop |-> ##[0:1] (domainOff[4] || $past(domainOff[4])))
    else $error("clock stop without clock idle");
  clk_deps_a: assert property (domainOff[4] |-> &domainOff[2:0] && &domainOff[8:5])
    else $error("clock idle with a domain awake");
  periph_sel_a: assert property (|periphOff |-> ##[0:1] (domainOff[3] || $past(domainOff[3])))
    else $error("peripheral off without request");
  buserr_irq_a: assert property (busErrIrq |-> irq)
    else $error("bus error irq without irq");
  off_cause_a: assert property ($rose(|domainOff) |->
    $past(idleExec, 2) || $past(idleExec, 3) || $past(idleExec, 4))
    else $error("domain off without idle");
  wake_cause_a: assert property ($fell(|domainOff) |->
    $past(wakeEvent, 2) || $past(wakeEvent, 3) || $past(wakeEvent, 4))
    else $error("domain woke without wake");
endmodule

bind idle_domain_control idle_domain_control_asserts chk_i (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .idleExec(idleExec), .wakeEvent(wakeEvent),
  .domainOff(domainOff), .periphOff(periphOff), .sysClkStop(sysClkStop), .busErrIrq(busErrIrq), .irq(irq));

/* File: tb/idle_domain_control_tb.sv */
// testbench of the idle domain control block
`timescale 1ns/1ps
`include "idle_domain_control_consts.svh"
module idle_domain_control_tb
  import idle_domain_control_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, idleExec, wakeEvent;
  logic sysClkStop, busErrIrq, irq, err, e;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [15:0] domainOff, periphOff, cfg, sel, off, mask;
  logic [15:0] cases [9] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010,
    16'h03FB, 16'h03FF, 16'h0200, 16'h03F7};
  int numErrors, numChecks;

  idle_domain_control DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idleExec(idleExec), .wakeEvent(wakeEvent), .domainOff(domainOff), .periphOff(periphOff),
    .sysClkStop(sysClkStop), .busErrIrq(busErrIrq), .irq(irq));

  // ----
  // tasks
  // ----
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    numChecks++;
    if (g !== x)
    begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask

  // expected outcome of one idle, from the request layout alone
  function automatic logic expErr(input logic [15:0] c);
    expErr = c[`IDC_BIT_CLKGEN] && (c & `IDC_CLKGEN_DEPS) != `IDC_CLKGEN_DEPS;
  endfunction

  function automatic logic [15:0] expOff(input logic [15:0] c);
    expOff = expErr(c) ? 16'h0000 : c & 16'h01FF;
  endfunction

  // releases then idles one edge, so back-to-back calls never drive twice
  task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {14'h0, i, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // looked at mid-cycle, where pready and prdata have settled; a hang ends at the watchdog
    do
      @(negedge clk);
    while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  task automatic rchk(input string n, input logic [15:0] i, input logic [31:0] x);
    bus(0, i, 0);
    chk(n, x, rdat);
  endtask

  task automatic step(input logic k);
    if (k)
      idleExec <= 1;
    else
      wakeEvent <= 1;
    @(posedge clk);
    idleExec <= 0;
    wakeEvent <= 0;
    repeat (5) @(posedge clk);
  endtask

  task automatic stopTest;
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----
  // sequence
  // ----
  initial
  begin
    #200000;
    numErrors++;
    stopTest;
  end

  initial
  begin
    {rst, psel, penable, pwrite, idleExec, wakeEvent} = 6'h20;
    {paddr, pwdata} = 0;
    void'($urandom(61));
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rchk("config", `IDC_IDX_CONFIG, 0);
    rchk("state", `IDC_IDX_STATE, 0);
    sel = 16'($urandom) & 16'h3FFF;
    bus(1, `IDC_IDX_SELECT, sel);
    bus(1, `IDC_IDX_STATE, 32'hFFFF);
    rchk("state", `IDC_IDX_STATE, 0);
    bus(0, 16'h0003, 0);
    chk("slverr", 1, err);
    // corner configs first, random ones after; clock needs confirm and deps
    for (int t = 0; t < 14; t++)
    begin
      cfg = t < 9 ? cases[t] : 16'($urandom);
      mask = 16'($urandom) & 16'h0007;
      e = expErr(cfg);
      off = expOff(cfg);
      bus(1, `IDC_IDX_MASK, mask);
      bus(1, `IDC_IDX_CONFIG, cfg);
      rchk("config", `IDC_IDX_CONFIG, cfg & 16'h03FF);
      step(1);
      chk("off", off, domainOff);
      chk("clkstop", off[4], sysClkStop);
      chk("periph", off[3] ? sel : 16'h0000, periphOff);
      rchk("state", `IDC_IDX_STATE, off);
      chk("irq", |(mask & (e ? 16'h1 : 16'h2)), irq);
      chk("buserr", e & mask[0], busErrIrq);
      step(0);
      chk("wake", 0, domainOff);
      rchk("state", `IDC_IDX_STATE, 0);
      rchk("event", `IDC_IDX_EVENT, e ? 1 : 6);
      bus(1, `IDC_IDX_EVENT, 7);
      rchk("event", `IDC_IDX_EVENT, 0);
      chk("irq", 0, irq);
      $display("test %0d done", t);
    end
    stopTest;
  end
endmodule
